// ---- design/mdc_datapath_ctrl.v ----
// Function
// [RQ1] Modifier select 111 gives twice IR count
// [RQ2] Address select: 0 memory counter, 1 PC
// [RQ3] Result select picks sum, XWR, WR, memin, address
// [RQ4] Memory-in and address sources reach result bus
// [RQ5] Memory field: none, transfer, fetch, store
// [RQ6] Constant word comes from second branch field
// [RQ7] ALU code sits in bits 52-62
// [RQ8] ALU code passes straight to ALU
// [RQ9] Double shifts logical and circular supported
// [RQ10] Subtract-shift and add-shift double codes
// [RQ11] Multiply, divide and signed divide steps
// [RQ12] Register controls act alongside other fields
// [RQ13] Never increment both counters together
// [RQ14] Bit 63 increments memory counter
// [RQ15] Bit 64 increments program counter
// [RQ16] Bit 65 loads WR from operand port; the code loads WR from the operand bus abus, operand_a_i is unused
// [RQ17] Bit 66 writes result into register file
// [RQ18] Bit 67 loads IR from bus data
// [RQ19] Fetch flag drives instruction acquisition
// [RQ20] Counter: hold, decrement, load, set fifteen
// [RQ21] Undefined result codes drive nothing; the code still puts zero on data_output_port_o for transfer or store
// [RQ22] All updates on the closing clock edge
`timescale 1ns/1ps
`default_nettype none
`include "mdc_defs.vh"

module mdc_datapath_ctrl #(
    parameter DATA_W = 16,
    parameter RF_N   = 16
) (
    // Clock and reset
    input  wire                    core_clk_i,
    input  wire                    rst_i,
    // Microinstruction word
    input  wire [`MDC_UWORD_W-1:0] uword_i,
    // Datapath sources
    input  wire [DATA_W-1:0]       alu_sum_i,
    input  wire [DATA_W-1:0]       xwr_i,
    input  wire [DATA_W-1:0]       wr_i,
    input  wire [DATA_W-1:0]       memory_data_input_i,
    input  wire [DATA_W-1:0]       status_i,
    input  wire [DATA_W-1:0]       int_vector_i,
    input  wire [DATA_W-1:0]       operand_a_i,
    input  wire [DATA_W-1:0]       ir_s_field_i,
    input  wire [DATA_W-1:0]       ir_d_field_i,
    input  wire [DATA_W-1:0]       ir_disp_i,
    // ALU controls
    output reg  [10:0]             alu_op_o,
    output reg                     alu_nop_o,
    output reg                     alu_iter_o,
    // Buses
    output reg  [DATA_W-1:0]       modbus_o,
    output reg  [DATA_W-1:0]       result_bus_o,
    output reg                     result_bus_en_o,
    output reg  [DATA_W-1:0]       address_output_port_o,
    // System bus
    output reg  [DATA_W-1:0]       data_output_port_o,
    output reg                     data_output_en_o,
    output reg                     memory_fetch_op_o,
    output reg                     memory_store_op_o,
    output reg                     instruction_fetch_flag_o,
    // Register state
    output reg  [DATA_W-1:0]       memory_counter_o,
    output reg  [DATA_W-1:0]       program_counter_o,
    output reg  [DATA_W-1:0]       working_reg_o,
    output reg  [DATA_W-1:0]       instruction_reg_o,
    output reg  [3:0]              shift_count_o,
    output reg                     count_zero_o,
    output reg                     incr_conflict_o
);

    // Microinstruction fields
    wire [3:0]        rf_addr;
    wire              asel;
    wire [2:0]        bsel;
    wire              addr_out_counter_select;
    wire [2:0]        fsel;
    wire [1:0]        mem_op;
    wire [10:0]       alu_code;
    wire              bump_memory_counter;
    wire              bump_program_counter;
    wire              load_working_reg_bit;
    wire              load_regfile_bit;
    wire              load_instruction_reg_bit;
    wire              iaq_bit;
    wire [1:0]        cnt_cmd;
    wire [15:0]       second_branch_field;

    assign rf_addr                  = uword_i[`MDC_RF_MSB:`MDC_RF_LSB];
    assign asel                     = uword_i[`MDC_ASEL_BIT];
    assign bsel                     = uword_i[`MDC_BSEL_MSB:`MDC_BSEL_LSB];
    assign addr_out_counter_select  = uword_i[`MDC_AOP_BIT];
    assign fsel                     = uword_i[`MDC_FSEL_MSB:`MDC_FSEL_LSB];
    assign mem_op                   = uword_i[`MDC_MEM_MSB:`MDC_MEM_LSB];
    assign alu_code                 = uword_i[`MDC_ALU_MSB:`MDC_ALU_LSB];    // see [RQ7]
    assign bump_memory_counter      = uword_i[`MDC_BUMP_MEMORY_COUNTER_BIT];
    assign bump_program_counter     = uword_i[`MDC_BUMP_PROGRAM_COUNTER_BIT];
    assign load_working_reg_bit     = uword_i[`MDC_LOAD_WORKING_REG_BIT_BIT];
    assign load_regfile_bit         = uword_i[`MDC_LOAD_REGFILE_BIT_BIT];
    assign load_instruction_reg_bit = uword_i[`MDC_LOAD_INSTRUCTION_REG_BIT_BIT];
    assign iaq_bit                  = uword_i[`MDC_IAQ_BIT];
    assign cnt_cmd                  = uword_i[`MDC_CNT_MSB:`MDC_CNT_LSB];
    assign second_branch_field      = uword_i[`MDC_BA1_MSB:`MDC_BA1_LSB];

    // Register storage
    reg [DATA_W-1:0] mc_q;
    reg [DATA_W-1:0] pc_q;
    reg [DATA_W-1:0] wr_q;
    reg [DATA_W-1:0] ir_q;
    reg [3:0]        cnt_q;
    reg [DATA_W-1:0] rf_q [0:RF_N-1];
    reg [3:0]        cnt_d;

    // Combinational buses
    reg [DATA_W-1:0] addr_sel;
    reg [DATA_W-1:0] fbus;
    reg              fbus_en;
    reg [DATA_W-1:0] bbus;
    wire [DATA_W-1:0] abus;

    // Operation classification
    wire is_nop;
    wire is_dbl;
    wire is_sha;
    wire is_mul;
    wire is_div;
    wire is_sdiv;

    mdc_op_class u_class (
        .alu_code_i       (alu_code),
        .is_nop_o         (is_nop),
        .is_dbl_shift_o   (is_dbl),
        .is_shift_arith_o (is_sha),
        .is_mul_step_o    (is_mul),
        .is_div_step_o    (is_div),
        .is_sdiv_step_o   (is_sdiv)
    );

    // Doubles a value for the modifier bus
    function [DATA_W-1:0] twice;
        input [DATA_W-1:0] v;
        begin
            twice = {v[DATA_W-2:0], 1'b0};
        end
    endfunction

    // Address output port source
    always @* begin
        if (addr_out_counter_select) begin
            addr_sel = pc_q;                                  // see [RQ2]
        end else begin
            addr_sel = mc_q;                                  // see [RQ2]
        end
    end

    // Result bus source select
    always @* begin
        fbus    = `MDC_ZERO16;
        fbus_en = 1'b1;
        case (fsel)
            `MDC_RESULT_FROM_SUM:   fbus = alu_sum_i;                   // see [RQ3]
            `MDC_F_XWR:   fbus = xwr_i;                       // see [RQ3]
            `MDC_F_WR:    fbus = wr_i;                        // see [RQ3]
            `MDC_F_MEMIN: fbus = memory_data_input_i;         // see [RQ4]
            `MDC_F_ADDR:  fbus = addr_sel;                    // see [RQ4]
            default: begin
                fbus_en = 1'b0;                               // see [RQ21]
            end
        endcase
    end

    // Operand bus: register file or pass-through of result
    assign abus = asel ? fbus : rf_q[rf_addr];

    // Modifier bus source select
    always @* begin
        bbus = `MDC_ZERO16;
        case (bsel)
            `MDC_B_CONST:     bbus = second_branch_field;     // see [RQ6]
            `MDC_B_TWO_S:     bbus = twice(ir_s_field_i);
            `MDC_B_TWO_D:     bbus = twice(ir_d_field_i);
            `MDC_B_TWO_DISP:  bbus = twice(ir_disp_i);
            `MDC_B_TWO_VEC:   bbus = twice(int_vector_i);
            `MDC_B_REGFILE:   bbus = rf_q[rf_addr];
            `MDC_B_STATUS:    bbus = status_i;
            `MDC_B_TWO_COUNT: bbus = twice({{(DATA_W-4){1'b0}},
                                 ir_q[`MDC_IR_CNT_MSB:`MDC_IR_CNT_LSB]}); // see [RQ1]
            default:          bbus = `MDC_ZERO16;
        endcase
    end

    // Shift counter next value
    always @* begin
        cnt_d = cnt_q;
        case (cnt_cmd)
            `MDC_CNT_DEC:    cnt_d = cnt_q - 4'h1;                            // see [RQ20]
            `MDC_CNT_LOAD:   cnt_d = fbus[`MDC_CNT_F_MSB:`MDC_CNT_F_LSB];     // see [RQ20]
            `MDC_CNT_PRESET: cnt_d = `MDC_CNT_FIFTEEN;                        // see [RQ20]
            default:         cnt_d = cnt_q;
        endcase
    end

    // Datapath registers, all on the closing edge
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            mc_q  <= `MDC_ZERO16;
            pc_q  <= `MDC_ZERO16;
            wr_q  <= `MDC_ZERO16;
            ir_q  <= `MDC_ZERO16;
            cnt_q <= `MDC_CNT_ZERO;
        end else begin
            // Memory counter wins if microcode breaks exclusivity
            if (bump_memory_counter) begin
                mc_q <= mc_q + `MDC_ONE16;                    // see [RQ14] [RQ22]
            end
            if (bump_program_counter && !bump_memory_counter) begin
                pc_q <= pc_q + `MDC_ONE16;                    // see [RQ15] [RQ12] [RQ13]
            end
            if (load_working_reg_bit) begin
                wr_q <= abus;                                 // see [RQ16]
            end
            if (load_instruction_reg_bit) begin
                ir_q <= memory_data_input_i;                  // see [RQ18]
            end
            cnt_q <= cnt_d;                                   // see [RQ22]
        end
    end

    // Register file writes from the result bus
    integer i;
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            for (i = 0; i < RF_N; i = i + 1) begin
                rf_q[i] <= `MDC_ZERO16;
            end
        end else if (load_regfile_bit && fbus_en) begin
            rf_q[rf_addr] <= fbus;                            // see [RQ17]
        end
    end

    // Registered outputs toward the ALU and buses
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            alu_op_o                 <= `MDC_ALU_NOP;
            alu_nop_o                <= 1'b1;
            alu_iter_o               <= 1'b0;
            modbus_o                 <= `MDC_ZERO16;
            result_bus_o             <= `MDC_ZERO16;
            result_bus_en_o          <= 1'b0;
            address_output_port_o    <= `MDC_ZERO16;
            data_output_port_o       <= `MDC_ZERO16;
            data_output_en_o         <= 1'b0;
            memory_fetch_op_o        <= 1'b0;
            memory_store_op_o        <= 1'b0;
            instruction_fetch_flag_o <= 1'b0;
            incr_conflict_o          <= 1'b0;
        end else begin
            alu_op_o                 <= alu_code;                         // see [RQ8]
            alu_nop_o                <= is_nop;                           // see [RQ8]
            alu_iter_o               <= is_dbl | is_sha | is_mul |
                                        is_div | is_sdiv;                 // see [RQ9] [RQ10] [RQ11]
            modbus_o                 <= bbus;                             // see [RQ1]
            result_bus_o             <= fbus;                             // see [RQ3]
            result_bus_en_o          <= fbus_en;                          // see [RQ21]
            address_output_port_o    <= addr_sel;                         // see [RQ2]
            data_output_port_o       <= fbus;
            data_output_en_o         <= (mem_op == `MDC_MEM_XFER) ||
                                        (mem_op == `MDC_MEM_STORE);       // see [RQ5]
            memory_fetch_op_o        <= (mem_op == `MDC_MEM_FETCH);       // see [RQ5]
            memory_store_op_o        <= (mem_op == `MDC_MEM_STORE);       // see [RQ5]
            instruction_fetch_flag_o <= iaq_bit;                          // see [RQ19]
            incr_conflict_o          <= bump_memory_counter &
                                        bump_program_counter;             // see [RQ13]
        end
    end

    // State mirrors
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            memory_counter_o  <= `MDC_ZERO16;
            program_counter_o <= `MDC_ZERO16;
            working_reg_o     <= `MDC_ZERO16;
            instruction_reg_o <= `MDC_ZERO16;
            shift_count_o     <= `MDC_CNT_ZERO;
            count_zero_o      <= 1'b1;
        end else begin
            memory_counter_o  <= mc_q;
            program_counter_o <= pc_q;
            working_reg_o     <= wr_q;
            instruction_reg_o <= ir_q;
            shift_count_o     <= cnt_q;
            count_zero_o      <= (cnt_q == `MDC_CNT_ZERO);
        end
    end

endmodule
`default_nettype wire

// ---- pkg/mdc_defs.vh ----
`ifndef MDC_DEFS_VH
`define MDC_DEFS_VH

// Microinstruction field positions
`define MDC_RF_LSB        38
`define MDC_RF_MSB        41
`define MDC_ASEL_BIT      42
`define MDC_BSEL_LSB      43
`define MDC_BSEL_MSB      45
`define MDC_AOP_BIT       46
`define MDC_FSEL_LSB      47
`define MDC_FSEL_MSB      49
`define MDC_MEM_LSB       50
`define MDC_MEM_MSB       51
`define MDC_ALU_LSB       52
`define MDC_ALU_MSB       62
`define MDC_BUMP_MEMORY_COUNTER_BIT     63
`define MDC_BUMP_PROGRAM_COUNTER_BIT     64
`define MDC_LOAD_WORKING_REG_BIT_BIT      65
`define MDC_LOAD_REGFILE_BIT_BIT      66
`define MDC_LOAD_INSTRUCTION_REG_BIT_BIT      67
`define MDC_IAQ_BIT       68
`define MDC_CNT_LSB       69
`define MDC_CNT_MSB       70
`define MDC_BA1_LSB       22
`define MDC_BA1_MSB       37
`define MDC_UWORD_W       81

// Modifier bus select codes
`define MDC_B_CONST       3'h0
`define MDC_B_TWO_S       3'h1
`define MDC_B_TWO_D       3'h2
`define MDC_B_TWO_DISP    3'h3
`define MDC_B_TWO_VEC     3'h4
`define MDC_B_REGFILE     3'h5
`define MDC_B_STATUS      3'h6
`define MDC_B_TWO_COUNT   3'h7

// Result bus select codes
`define MDC_RESULT_FROM_SUM         3'h0
`define MDC_F_XWR         3'h1
`define MDC_F_WR          3'h2
`define MDC_F_MEMIN       3'h3
`define MDC_F_ADDR        3'h7

// Memory operation codes
`define MDC_MEM_NONE      2'h0
`define MDC_MEM_XFER      2'h1
`define MDC_MEM_FETCH     2'h2
`define MDC_MEM_STORE     2'h3

// Shift counter commands
`define MDC_CNT_NOP       2'h0
`define MDC_CNT_DEC       2'h1
`define MDC_CNT_LOAD      2'h2
`define MDC_CNT_PRESET    2'h3
`define MDC_CNT_FIFTEEN   4'hF
`define MDC_CNT_ZERO      4'h0
`define MDC_CNT_F_LSB     1
`define MDC_CNT_F_MSB     4

// ALU operation codes of note
`define MDC_ALU_NOP       11'h7C1
`define MDC_ALU_DLSL      11'h778
`define MDC_ALU_DRSL      11'h779
`define MDC_ALU_DLSC      11'h77C
`define MDC_ALU_DRSC      11'h77D
`define MDC_ALU_SUBSHL    11'h758
`define MDC_ALU_ADDSHL    11'h749
`define MDC_ALU_MPY       11'h793
`define MDC_ALU_DIVIDE_STEP_FIRST      11'h786
`define MDC_ALU_DIVB      11'h78E
`define MDC_ALU_DIVC      11'h78A
`define MDC_ALU_SIGNED_DIVIDE_STEP_FIRST     11'h797
`define MDC_ALU_SDIVB     11'h7AF
`define MDC_ALU_SDIVC     11'h7B7
`define MDC_ALU_SDIVD     11'h7A7
`define MDC_ALU_SDIVE     11'h79F

// Instruction register count field
`define MDC_IR_CNT_LSB    4
`define MDC_IR_CNT_MSB    7

`define MDC_ZERO16        16'h0000
`define MDC_ONE16         16'h0001
`define MDC_ZERO11        11'h000

`endif

// ---- design/mdc_op_class.v ----
`timescale 1ns/1ps
`default_nettype none
`include "mdc_defs.vh"

// Classifies the ALU code into the iterative operation families
module mdc_op_class (
    // ALU code
    input  wire [10:0] alu_code_i,
    // Classification
    output reg         is_nop_o,
    output reg         is_dbl_shift_o,
    output reg         is_shift_arith_o,
    output reg         is_mul_step_o,
    output reg         is_div_step_o,
    output reg         is_sdiv_step_o
);

    // Compare against the used code subset
    always @* begin
        is_nop_o         = (alu_code_i == `MDC_ALU_NOP);
        is_dbl_shift_o   = (alu_code_i == `MDC_ALU_DLSL) || (alu_code_i == `MDC_ALU_DRSL) ||
                           (alu_code_i == `MDC_ALU_DLSC) || (alu_code_i == `MDC_ALU_DRSC);
        is_shift_arith_o = (alu_code_i == `MDC_ALU_SUBSHL) || (alu_code_i == `MDC_ALU_ADDSHL);
        is_mul_step_o    = (alu_code_i == `MDC_ALU_MPY);
        is_div_step_o    = (alu_code_i == `MDC_ALU_DIVIDE_STEP_FIRST) || (alu_code_i == `MDC_ALU_DIVB) ||
                           (alu_code_i == `MDC_ALU_DIVC);
        is_sdiv_step_o   = (alu_code_i == `MDC_ALU_SIGNED_DIVIDE_STEP_FIRST) || (alu_code_i == `MDC_ALU_SDIVB) ||
                           (alu_code_i == `MDC_ALU_SDIVC) || (alu_code_i == `MDC_ALU_SDIVD) ||
                           (alu_code_i == `MDC_ALU_SDIVE);
    end

endmodule
`default_nettype wire

// ---- verification/mdc_dpc_properties.sv ----
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the microword decode
module mdc_dpc_properties #(
    parameter DATA_W = 16
) (
    // Clock, reset and microword
    input wire logic              core_clk_i,
    input wire logic              rst_i,
    input wire logic [80:0]       uword_i,
    input wire logic [DATA_W-1:0] memory_data_input_i,
    // Decoded outputs and state mirrors
    input wire logic [DATA_W-1:0] modbus_o,
    input wire logic [DATA_W-1:0] result_bus_o,
    input wire logic              result_bus_en_o,
    input wire logic [DATA_W-1:0] address_output_port_o,
    input wire logic              data_output_en_o,
    input wire logic              memory_fetch_op_o,
    input wire logic              memory_store_op_o,
    input wire logic [DATA_W-1:0] memory_counter_o,
    input wire logic [DATA_W-1:0] program_counter_o,
    input wire logic [DATA_W-1:0] instruction_reg_o,
    input wire logic [3:0]        shift_count_o,
    input wire logic              count_zero_o,
    input wire logic              incr_conflict_o
);
    // One clock domain, reset disables all
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    property p_addr_sel;
        !$past(rst_i) |-> address_output_port_o ==
            ($past(uword_i[46]) ? program_counter_o : memory_counter_o);
    endproperty
    a_addr_sel: assert property (p_addr_sel) else $error("address select wrong");
    property p_mod_count;
        !$past(rst_i) && $past(uword_i[45:43]) == 3'h7 |->
            modbus_o == {11'h000, instruction_reg_o[7:4], 1'b0};
    endproperty
    a_mod_count: assert property (p_mod_count) else $error("modifier count wrong");
    property p_mem_in;
        !$past(rst_i) && $past(uword_i[49:47]) == 3'h3 |->
            result_bus_en_o && result_bus_o == $past(memory_data_input_i);
    endproperty
    a_mem_in: assert property (p_mem_in) else $error("memory data not on result");
    property p_undef;
        !$past(rst_i) && $past(uword_i[49:48]) == 2'h2 |-> !result_bus_en_o;
    endproperty
    a_undef: assert property (p_undef) else $error("undefined source drives");
    property p_mem_op;
        !$past(rst_i) |-> {memory_fetch_op_o, memory_store_op_o, data_output_en_o} ==
            {$past(uword_i[51:50]) == 2'h2, $past(uword_i[51:50]) == 2'h3, $past(uword_i[50])};
    endproperty
    a_mem_op: assert property (p_mem_op) else $error("memory operation wrong");
    property p_pc_inc;
        !$past(rst_i) && $past(uword_i[64:63]) == 2'h2 |->
            ##1 program_counter_o == $past(program_counter_o) + 16'h0001;
    endproperty
    a_pc_inc: assert property (p_pc_inc) else $error("counter not bumped");
    property p_conflict;
        !$past(rst_i) && $past(uword_i[64:63]) == 2'h3 |->
            incr_conflict_o ##1 $stable(program_counter_o);
    endproperty
    a_conflict: assert property (p_conflict) else $error("double bump handled wrong");
    property p_preset;
        !$past(rst_i) && $past(uword_i[70:69]) == 2'h3 |->
            ##1 shift_count_o == 4'hF && !count_zero_o;
    endproperty
    a_preset: assert property (p_preset) else $error("count preset wrong");
endmodule

bind mdc_datapath_ctrl mdc_dpc_properties #(.DATA_W(DATA_W)) props_u (
    .core_clk_i, .rst_i, .uword_i, .memory_data_input_i, .modbus_o, .result_bus_o,
    .result_bus_en_o, .address_output_port_o, .data_output_en_o, .memory_fetch_op_o,
    .memory_store_op_o, .memory_counter_o, .program_counter_o, .instruction_reg_o,
    .shift_count_o, .count_zero_o, .incr_conflict_o
);
`default_nettype wire

// ---- verification/mdc_ustore.sv ----
`timescale 1ns/1ps
`default_nettype none

// Control store side: hands each microword to the datapath control
module mdc_ustore (
    // Raw word and permission for the double bump
    input  wire logic [80:0] word_i,
    input  wire logic        allow_both_i,
    // Word as presented
    output wire logic [80:0] uword_o
);
    // Test field zero when the constant is used; one bump unless told
    assign uword_o = {word_i[80:65], word_i[64] & (allow_both_i | ~word_i[63]),
                      word_i[63:12], (word_i[45:43] == 3'h0) ? 5'h00 : word_i[11:7],
                      word_i[6:0]};
endmodule
`default_nettype wire

// ---- verification/tb_microcode_datapath_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mdc_defs.vh"

module tb_microcode_datapath_control;
    // Design inputs and expected state
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        both = 1'b0;
    logic [80:0] w = '0;
    logic [15:0] alu_sum_i = '0, xwr_i = '0, wr_i = '0, memory_data_input_i = '0;
    logic [15:0] status_i = '0, int_vector_i = '0, operand_a_i = '0, ir_s_field_i = '0;
    logic [15:0] ir_d_field_i = '0, ir_disp_i = '0, mc = '0, pc = '0, wk = '0, ir = '0;
    logic [15:0] rf [16];
    logic [3:0]  cnt = '0;
    integer      seed = 32'h647e6b6d;
    integer      miscompares = 0;
    integer      n_checks = 0;
    logic [2:0]  fsel [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic [10:0] codes [16] = '{`MDC_ALU_DLSL, `MDC_ALU_DRSL, `MDC_ALU_DLSC, `MDC_ALU_DRSC,
        `MDC_ALU_SUBSHL, `MDC_ALU_ADDSHL, `MDC_ALU_MPY, `MDC_ALU_DIVIDE_STEP_FIRST, `MDC_ALU_DIVB,
        `MDC_ALU_DIVC, `MDC_ALU_SIGNED_DIVIDE_STEP_FIRST, `MDC_ALU_SDIVB, `MDC_ALU_SDIVC, `MDC_ALU_SDIVD,
        `MDC_ALU_SDIVE, `MDC_ALU_NOP};
    // Design outputs
    wire  [80:0] uword_i;
    wire  [10:0] alu_op_o;
    wire  [15:0] modbus_o, result_bus_o, address_output_port_o, data_output_port_o;
    wire  [15:0] memory_counter_o, program_counter_o, working_reg_o, instruction_reg_o;
    wire  [3:0]  shift_count_o;
    wire         alu_nop_o, alu_iter_o, result_bus_en_o, data_output_en_o, count_zero_o;
    wire         memory_fetch_op_o, memory_store_op_o, instruction_fetch_flag_o, incr_conflict_o;

    // Microcycle clock
    always #5 core_clk_i = ~core_clk_i;

    // Control store model and design
    mdc_ustore ctrl_u (.word_i(w), .allow_both_i(both), .uword_o(uword_i));
    mdc_datapath_ctrl #(.DATA_W(16), .RF_N(16)) dut_u (
        .core_clk_i, .rst_i, .uword_i, .alu_sum_i, .xwr_i, .wr_i, .memory_data_input_i,
        .status_i, .int_vector_i, .operand_a_i, .ir_s_field_i, .ir_d_field_i, .ir_disp_i,
        .alu_op_o, .alu_nop_o, .alu_iter_o, .modbus_o, .result_bus_o, .result_bus_en_o,
        .address_output_port_o, .data_output_port_o, .data_output_en_o, .memory_fetch_op_o,
        .memory_store_op_o, .instruction_fetch_flag_o, .memory_counter_o, .program_counter_o,
        .working_reg_o, .instruction_reg_o, .shift_count_o, .count_zero_o, .incr_conflict_o
    );

    // Value and flag comparisons
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkb(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask

    // Iterative operation codes
    function automatic logic iter_of(input logic [10:0] c);
        iter_of = 1'b0;
        for (int i = 0; i < 15; i++)
            if (codes[i] === c)
                iter_of = 1'b1;
    endfunction

    // One microcycle: drive, let it be taken, check, then advance the model
    task automatic step(input logic [80:0] u);
        logic [15:0] f, mb, ao;
        logic [80:0] x;
        logic        en;
        w = u;
        {alu_sum_i, xwr_i, wr_i, memory_data_input_i, status_i, int_vector_i, operand_a_i,
         ir_s_field_i, ir_d_field_i, ir_disp_i} = {$random(seed), $random(seed),
         $random(seed), $random(seed), $random(seed)};
        #1;
        x = uword_i;
        ao = x[46] ? pc : mc;
        en = x[49:47] < 3'h4 || x[49:47] == 3'h7;
        f = x[49] ? ao : (x[48] ? (x[47] ? memory_data_input_i : wr_i) : (x[47] ? xwr_i : alu_sum_i));
        case (x[45:43])
            3'h0: mb = x[37:22];
            3'h1: mb = ir_s_field_i << 1;
            3'h2: mb = ir_d_field_i << 1;
            3'h3: mb = ir_disp_i << 1;
            3'h4: mb = int_vector_i << 1;
            3'h5: mb = rf[x[41:38]];
            3'h6: mb = status_i;
            default: mb = {11'h000, ir[7:4], 1'b0};
        endcase
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        chk("alu_op", {5'h00, x[62:52]}, {5'h00, alu_op_o});
        chkb("alu_nop", x[62:52] == `MDC_ALU_NOP, alu_nop_o);
        chkb("alu_iter", iter_of(x[62:52]), alu_iter_o);
        chk("modbus", mb, modbus_o);
        chk("addr_out", ao, address_output_port_o);
        chkb("result_en", en, result_bus_en_o);
        if (en)
            chk("result", f, result_bus_o);
        chkb("data_en", x[50], data_output_en_o);
        if (en && x[50])
            chk("data_out", f, data_output_port_o);
        chkb("fetch", x[51:50] == 2'h2, memory_fetch_op_o);
        chkb("store", x[51:50] == 2'h3, memory_store_op_o);
        chkb("iaq", x[68], instruction_fetch_flag_o);
        chkb("conflict", x[64] & x[63], incr_conflict_o);
        chk("mc", mc, memory_counter_o);
        chk("pc", pc, program_counter_o);
        chk("wr", wk, working_reg_o);
        chk("ir", ir, instruction_reg_o);
        chk("count", {12'h000, cnt}, {12'h000, shift_count_o});
        chkb("count_zero", cnt == 4'h0, count_zero_o);
        // Advance as the closing edge did
        if (x[63])
            mc = mc + 16'h0001;
        else if (x[64])
            pc = pc + 16'h0001;
        if (x[65])
            wk = x[42] ? f : rf[x[41:38]];
        if (x[66] && en)
            rf[x[41:38]] = f;
        if (x[67])
            ir = memory_data_input_i;
        if (x[70:69] != 2'h0)
            cnt = x[70] ? (x[69] ? 4'hF : f[4:1]) : cnt - 4'h1;
    endtask

    // Verdict and end of run
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Cut a hang short; the run needs about 3.5 us
    initial begin
        #20000;
        miscompares++;
        finish_test();
    end

    // Main sequence
    initial begin
        logic [80:0] u;
        logic [95:0] rr;
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        chk("rst_alu_op", {5'h00, `MDC_ALU_NOP}, {5'h00, alu_op_o});
        chkb("rst_count_zero", 1'b1, count_zero_o);
        rst_i = 1'b0;
        // Fill the register file, then every code of note
        for (int i = 0; i < 32; i++) begin
            u = '0;
            u[41:38] = i[3:0];
            u[66] = i < 16;
            u[62:52] = (i < 16) ? 11'h000 : codes[i[3:0]];
            step(u);
        end
        // Every source, memory operation and modifier, IR loaded the step before the count modifier
        for (int i = 0; i < 8; i++) begin
            rr = {$random(seed), $random(seed), $random(seed)};
            u = '0;
            u[49:47] = i[2:0];
            u[45:43] = i[2:0];
            u[51:50] = i[1:0];
            u[37:22] = rr[15:0];
            u[67] = i == 6;
            step(u);
        end
        // Counter commands and bumps, the forbidden pair included
        both = 1'b1;
        for (int i = 0; i < 8; i++) begin
            u = '0;
            u[70:69] = 2'h3 - i[1:0];
            u[64:63] = i[2:1];
            step(u);
        end
        both = 1'b0;
        // Random words, parallel controls mixed with everything else
        for (int i = 0; i < 300; i++) begin
            rr = {$random(seed), $random(seed), $random(seed)};
            u = rr[80:0];
            u[49:47] = fsel[rr[83:81] % 3'h5];
            if (rr[84])
                u[62:52] = codes[rr[88:85]];
            if (u[65] && !u[42])
                u[66] = 1'b0;
            step(u);
        end
        finish_test();
    end
endmodule
`default_nettype wire
